// >>> verilog/prio_pkg.sv
package prio_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_REGS = 7;
    localparam int NUM_SRC  = 16;
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 3;
    localparam int FIELD_W  = 3;
    localparam int SRC_W    = 4;

    // ****************************************
    // Register indices on the plain port
    // ****************************************
    localparam logic [2:0] IDX_TIMER4_OC      = 3'h0;
    localparam logic [2:0] IDX_SERIAL2_TIMER5 = 3'h1;
    localparam logic [2:0] IDX_SPI_PORT2      = 3'h2;
    localparam logic [2:0] IDX_CAPTURE_3_5    = 3'h3;
    localparam logic [2:0] IDX_COMPARE5       = 3'h4;
    localparam logic [2:0] IDX_PARALLEL_PORT  = 3'h5;
    localparam logic [2:0] IDX_I2C_PORT2      = 3'h6;
    localparam logic [2:0] IDX_PENDING        = 3'h7;

    // ****************************************
    // Implemented bits
    // ****************************************
    localparam logic [15:0] MASK_TIMER4_OC      = 16'h7770;
    localparam logic [15:0] MASK_SERIAL2_TIMER5 = 16'h7777;
    localparam logic [15:0] MASK_SPI_PORT2      = 16'h0077;
    localparam logic [15:0] MASK_CAPTURE_3_5    = 16'h7770;
    localparam logic [15:0] MASK_COMPARE5       = 16'h0070;
    localparam logic [15:0] MASK_PARALLEL_PORT  = 16'h0070;
    localparam logic [15:0] MASK_I2C_PORT2      = 16'h0770;

    // ****************************************
    // Reset values, every field at level four
    // ****************************************
    localparam logic [15:0] RST_TIMER4_OC      = 16'h4440;
    localparam logic [15:0] RST_SERIAL2_TIMER5 = 16'h4444;
    localparam logic [15:0] RST_SPI_PORT2      = 16'h0044;
    localparam logic [15:0] RST_CAPTURE_3_5    = 16'h4440;
    localparam logic [15:0] RST_COMPARE5       = 16'h0040;
    localparam logic [15:0] RST_PARALLEL_PORT  = 16'h0040;
    localparam logic [15:0] RST_I2C_PORT2      = 16'h0440;

    localparam logic [15:0] REG_MASK [NUM_REGS] = '{
        MASK_TIMER4_OC, MASK_SERIAL2_TIMER5, MASK_SPI_PORT2,
        MASK_CAPTURE_3_5, MASK_COMPARE5, MASK_PARALLEL_PORT,
        MASK_I2C_PORT2};

    localparam logic [NUM_REGS-1:0][15:0] REG_RESET = {
        RST_I2C_PORT2, RST_PARALLEL_PORT, RST_COMPARE5,
        RST_CAPTURE_3_5, RST_SPI_PORT2, RST_SERIAL2_TIMER5,
        RST_TIMER4_OC};

    // ****************************************
    // Field codes and levels
    // ****************************************
    localparam logic [2:0] CODE_OFF   = 3'h0;
    localparam logic [2:0] CODE_LOW   = 3'h1;
    localparam logic [2:0] CODE_HIGH  = 3'h7;
    localparam logic [2:0] LEVEL_NONE = 3'h0;
    localparam logic [2:0] LEVEL_LOW  = 3'h1;
    localparam logic [2:0] LEVEL_HIGH = 3'h7;

    // ****************************************
    // Source order and field placement
    // ****************************************
    // 0 timer4, 1 compare4, 2 compare3, 3 serial2 tx, 4 serial2 rx,
    // 5 ext irq2, 6 timer5, 7 spi2 event, 8 spi2 fault, 9 capture5,
    // 10 capture4, 11 capture3, 12 compare5, 13 parallel port,
    // 14 i2c2 master, 15 i2c2 slave
    localparam logic [2:0] SRC_REG [NUM_SRC] = '{
        3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2,
        3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6};

    localparam int SRC_LSB [NUM_SRC] = '{
        12, 8, 4, 12, 8, 4, 0, 4,
        0, 12, 8, 4, 4, 4, 8, 4};

endpackage

// >>> verilog/prio_field_decode.sv
`timescale 1ns/1ps
`default_nettype none

module prio_field_decode
    import prio_pkg::*;
(
    // Field code
    input  wire logic [2:0] code,
    // Decoded level
    output logic      [2:0] level,
    output logic            enabled
);

    always_comb begin
        level   = LEVEL_NONE;
        enabled = 1'b0;
        unique case (code)
            CODE_HIGH: begin
                level   = LEVEL_HIGH;
                enabled = 1'b1;
            end
            CODE_LOW: begin
                level   = LEVEL_LOW;
                enabled = 1'b1;
            end
            CODE_OFF: begin
                level   = LEVEL_NONE;
                enabled = 1'b0;
            end
            default: begin
                level   = code;
                enabled = 1'b1;
            end
        endcase
    end

endmodule

`default_nettype wire

// >>> verilog/interrupt_priority_regs_b.sv
`timescale 1ns/1ps
`default_nettype none

module interrupt_priority_regs_b
    import prio_pkg::*;
(
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              reset,
    // Register port
    input  wire logic [prio_pkg::ADDR_W-1:0]       addr,
    input  wire logic [prio_pkg::DATA_W-1:0]       wdata,
    input  wire logic                              wr_en,
    input  wire logic                              rd_en,
    output logic      [prio_pkg::DATA_W-1:0]       rdata,
    // Raw source requests
    input  wire logic [prio_pkg::NUM_SRC-1:0]      src_flag,
    // Gated requests and levels
    output logic      [prio_pkg::NUM_SRC-1:0]      src_req,
    output logic      [prio_pkg::NUM_SRC-1:0][2:0] src_level,
    // Highest pending source
    output logic                                   best_valid,
    output logic      [2:0]                        best_level,
    output logic      [prio_pkg::SRC_W-1:0]        best_src
);

    import prio_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [NUM_REGS-1:0][DATA_W-1:0] prio;
        logic [DATA_W-1:0]               rdata;
        logic [NUM_SRC-1:0]              req;
        logic [NUM_SRC-1:0][2:0]         level;
        logic                            best_valid;
        logic [2:0]                      best_level;
        logic [SRC_W-1:0]                best_src;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic [NUM_SRC-1:0][2:0] dec_level;
    logic [NUM_SRC-1:0]      dec_enabled;

    // ****************************************
    // Per-source field decode
    // ****************************************
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
        prio_field_decode u_dec (
            .code    (state_reg.prio[SRC_REG[g]][SRC_LSB[g] +: FIELD_W]),
            .level   (dec_level[g]),
            .enabled (dec_enabled[g])
        );
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        state_next       = state_reg;
        state_next.rdata = '0;

        // Only implemented bits take a write
        if (wr_en && addr != IDX_PENDING) begin
            state_next.prio[addr] = wdata & REG_MASK[addr];
        end

        // Read data stand for one cycle only
        if (rd_en) begin
            unique case (addr)
                IDX_TIMER4_OC: begin
                    state_next.rdata = state_reg.prio[IDX_TIMER4_OC]
                                       & MASK_TIMER4_OC;
                end
                IDX_SERIAL2_TIMER5: begin
                    state_next.rdata = state_reg.prio[IDX_SERIAL2_TIMER5]
                                       & MASK_SERIAL2_TIMER5;
                end
                IDX_SPI_PORT2: begin
                    state_next.rdata = state_reg.prio[IDX_SPI_PORT2]
                                       & MASK_SPI_PORT2;
                end
                IDX_CAPTURE_3_5: begin
                    state_next.rdata = state_reg.prio[IDX_CAPTURE_3_5]
                                       & MASK_CAPTURE_3_5;
                end
                IDX_COMPARE5: begin
                    state_next.rdata = state_reg.prio[IDX_COMPARE5]
                                       & MASK_COMPARE5;
                end
                IDX_PARALLEL_PORT: begin
                    state_next.rdata = state_reg.prio[IDX_PARALLEL_PORT]
                                       & MASK_PARALLEL_PORT;
                end
                IDX_I2C_PORT2: begin
                    state_next.rdata = state_reg.prio[IDX_I2C_PORT2]
                                       & MASK_I2C_PORT2;
                end
                IDX_PENDING: begin
                    state_next.rdata = state_reg.req;
                end
            endcase
        end

        // Disabled sources are masked off
        state_next.req   = src_flag & dec_enabled;
        state_next.level = dec_level;

        // Highest level wins, lowest index on a tie
        state_next.best_valid = 1'b0;
        state_next.best_level = LEVEL_NONE;
        state_next.best_src   = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (state_next.req[i] && dec_level[i] > state_next.best_level) begin
                state_next.best_valid = 1'b1;
                state_next.best_level = dec_level[i];
                state_next.best_src   = SRC_W'(i);
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg.prio       <= REG_RESET;
            state_reg.rdata      <= '0;
            state_reg.req        <= '0;
            state_reg.level      <= '0;
            state_reg.best_valid <= 1'b0;
            state_reg.best_level <= LEVEL_NONE;
            state_reg.best_src   <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata      = state_reg.rdata;
    assign src_req    = state_reg.req;
    assign src_level  = state_reg.level;
    assign best_valid = state_reg.best_valid;
    assign best_level = state_reg.best_level;
    assign best_src   = state_reg.best_src;

endmodule

`default_nettype wire

// >>> tb/prio_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module prio_regs_monitor
    import prio_pkg::*;
(
    // Clock and reset
    input wire logic             clk,
    input wire logic             reset,
    // Register port
    input wire logic [2:0]       addr,
    input wire logic [15:0]      wdata,
    input wire logic             wr_en,
    input wire logic             rd_en,
    input wire logic [15:0]      rdata,
    // Requests
    input wire logic [15:0]      src_flag,
    input wire logic [15:0]      src_req,
    input wire logic [15:0][2:0] src_level,
    input wire logic             best_valid,
    input wire logic [2:0]       best_level,
    input wire logic [3:0]       best_src
);
    // ****
    // Checks
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence wr_reg;
        wr_en && addr != IDX_PENDING;
    endsequence
    sequence rd_same;
        rd_en && addr == $past(addr);
    endsequence
    rd_idle_a: assert property (!$past(rd_en) |-> rdata == 16'h0000)
        else $error("rdata not zero outside a read");
    unimpl_zero_a: assert property (
        rd_en && addr != IDX_PENDING
        |=> (rdata & ~REG_MASK[$past(addr)]) == 16'h0000)
        else $error("unimplemented bit read as one");
    wr_read_a: assert property (
        wr_reg ##1 rd_same
        |=> rdata == ($past(wdata, 2) & REG_MASK[$past(addr, 2)]))
        else $error("read after write mismatch");
    pend_read_a: assert property (
        rd_en && addr == IDX_PENDING |=> rdata == $past(src_req))
        else $error("pending read mismatch");
    req_gate_a: assert property (
        (src_req & ~$past(src_flag)) == 16'h0000)
        else $error("request without flag");
    best_any_a: assert property (best_valid == (src_req != 16'h0000))
        else $error("best valid mismatch");
    best_pick_a: assert property (
        best_valid |-> src_req[best_src] && best_level != 3'h0)
        else $error("best source not pending");
    none_zero_a: assert property (
        !best_valid |-> best_level == 3'h0 && best_src == 4'h0)
        else $error("best outputs not zero");
    reset_lvl_a: assert property (
        $past(reset) && !wr_en |=> src_level == {16{3'h4}})
        else $error("level after reset not four");
endmodule
bind interrupt_priority_regs_b prio_regs_monitor u_mon (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .src_flag(src_flag),
    .src_req(src_req), .src_level(src_level), .best_valid(best_valid),
    .best_level(best_level), .best_src(best_src));
`default_nettype wire

// >>> tb/interrupt_priority_regs_b_bench.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_regs_b_bench;
    import prio_pkg::*;
    logic             clk = 1'b0;
    logic             reset = 1'b1;
    logic [2:0]       addr = 3'h0;
    logic [15:0]      wdata = 16'h0000;
    logic             wr_en = 1'b0;
    logic             rd_en = 1'b0;
    logic [15:0]      src_flag = 16'h0000;
    logic [15:0]      rdata;
    logic [15:0]      src_req;
    logic [15:0][2:0] src_level;
    logic             best_valid;
    logic [2:0]       best_level;
    logic [3:0]       best_src;
    logic [47:0]      exp_lvl;
    int               failures = 0;
    int               checks_done = 0;
    interrupt_priority_regs_b u_dut (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .src_flag(src_flag),
        .src_req(src_req), .src_level(src_level), .best_valid(best_valid),
        .best_level(best_level), .best_src(best_src));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ****
    // Access tasks
    // ****
    task automatic cmp(input string n, input logic [47:0] e,
                       input logic [47:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        addr <= a;
        wdata <= d;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        cmp("rdata", {32'h0, e}, {32'h0, rdata});
    endtask
    // Ends a write burst, sets flags, waits until levels settle
    task automatic settle(input logic [15:0] f);
        @(posedge clk);
        wr_en <= 1'b0;
        src_flag <= f;
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        failures++;
        end_sim();
    end
    // ****
    // Tests
    // ****
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            settle(16'h0000);
            cmp("src_level", {16{3'h4}}, src_level);
            for (int i = 0; i < NUM_REGS; i++) begin
                rd(3'(i), REG_RESET[i]);
            end
            wr(IDX_COMPARE5, 16'h0010);
            @(posedge clk);
            wr_en <= 1'b0;
            reset <= 1'b1;
            @(posedge clk);
            reset <= 1'b0;
        end
        $display("test reset done");
        for (int i = 0; i < NUM_REGS; i++) begin
            wr(3'(i), 16'hffff);
            rd(3'(i), REG_MASK[i]);
            wr(3'(i), 16'h0000);
            rd(3'(i), 16'h0000);
        end
        $display("test masks done");
        for (int s = 0; s < NUM_SRC; s++) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                wr(3'(i), 16'h0000);
            end
            wr(SRC_REG[s], 16'h0007 << SRC_LSB[s]);
            settle(16'h0000);
            exp_lvl = '0;
            exp_lvl[s*3+:3] = 3'h7;
            cmp("placed level", exp_lvl, src_level);
        end
        $display("test placement done");
        for (int c = 0; c < 8; c++) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                wr(3'(i), {4{1'b0, 3'(c)}});
            end
            settle(16'hffff);
            cmp("code level", {16{3'(c)}}, src_level);
            cmp("best_valid", 48'(c != 0), 48'(best_valid));
            cmp("best_level", 48'(c), 48'(best_level));
            cmp("best_src", 48'h0, 48'(best_src));
            rd(IDX_PENDING, (c != 0) ? 16'hffff : 16'h0000);
        end
        $display("test codes done");
        for (int i = 0; i < NUM_REGS; i++) begin
            wr(3'(i), 16'h0000);
        end
        wr(IDX_SERIAL2_TIMER5, 16'h0100);
        wr(IDX_CAPTURE_3_5, 16'h0700);
        settle(16'hffff);
        cmp("best_src", 48'ha, 48'(best_src));
        rd(IDX_PENDING, 16'h0410);
        wr(IDX_PENDING, 16'hffff);
        rd(IDX_PENDING, 16'h0410);
        settle(16'h0010);
        cmp("best_level", 48'h1, 48'(best_level));
        cmp("best_src", 48'h4, 48'(best_src));
        $display("test pick done");
        end_sim();
    end
endmodule
`default_nettype wire
